//--- hw/bcd_consts.svh
// constants of the backlight control decoder
// assumes a 25 MHz system clock and a synchronous active-high reset
//
// How it works
// R01 - sub sinks follow the sub control input, main sinks the main one
// R02 - main group is three sinks, sub group is the fourth sink only
// R03 - sinks switch fully on or fully off with the input level
// R04 - host dims with a rate from 100 Hz to 200 kHz
// R05 - average brightness follows the input duty cycle
// R06 - all inputs low: sinks off at once, pump off after 15 ms
// R07 - an input rising before timeout keeps the pump and restarts the timer
// R08 - host holds a steady level when dimming is not wanted
// R09 - gain 1.5x to 2x below 3.33 V, back above 3.36 V
// R10 - gain 1x to 1.5x below 4.77 V, back above 4.81 V
// R11 - control and comparator inputs pass two flip-flops before use
// R12 - pump-off timer counts all-low time, cleared by any high input
`ifndef BCD_CONSTS_SVH
`define BCD_CONSTS_SVH

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define BCD_CLK_MHZ 25
`define BCD_PUMP_OFF_DELAY_US 15000
`define BCD_TMR_W 19

// ----------------------------------------------------------------------
// synchroniser
// ----------------------------------------------------------------------
`define BCD_SYNC_W 6
`define BCD_SYNC_RST 6'h00

// ----------------------------------------------------------------------
// gain codes, one-hot
// ----------------------------------------------------------------------
`define BCD_GAIN_1X 3'h1
`define BCD_GAIN_15X 3'h2
`define BCD_GAIN_2X 3'h4

`endif

//--- hw/bcd_pkg.sv
// types of the backlight control decoder
// assumes bcd_consts.svh is on the include path
`include "bcd_consts.svh"

package bcd_pkg;

  // gain selector states
  typedef enum logic [2:0] {
    BCD_G1X = `BCD_GAIN_1X,
    BCD_G15X = `BCD_GAIN_15X,
    BCD_G2X = `BCD_GAIN_2X
  } bcd_gain_e;

  // raw or synchronised input pins
  typedef struct packed {
    logic sub_group_ctrl_in;
    logic main_group_ctrl_in;
    logic vcc_below_3v33;
    logic vcc_above_3v36;
    logic vcc_below_4v77;
    logic vcc_above_4v81;
  } bcd_pins_s;

  // current sink enables
  typedef struct packed {
    logic main_sink_a;
    logic main_sink_b;
    logic main_sink_c;
    logic sub_sink;
  } bcd_sinks_s;

endpackage

//--- hw/bcd_sync2.sv
// two flip-flop level synchroniser, W bits wide
// assumes each bit is an independent level from outside i_clk's domain
`include "bcd_consts.svh"

module bcd_sync2 #(
  parameter int W = `BCD_SYNC_W
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // levels
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);

  logic [W-1:0] meta;

  // first stage feeds only the second
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      meta <= '0;
      o_sync <= '0;
    end else begin
      meta <= i_async; // see R11
      o_sync <= meta; // see R11
    end
  end

endmodule

//--- hw/bcd_top.sv
// backlight control decoder: group enables, pump-off timer, gain select
// assumes control pins and supply comparators are asynchronous levels
`include "bcd_consts.svh"

module bcd_top
  import bcd_pkg::*;
#(
  parameter int unsigned PUMP_OFF_CYCLES =
    `BCD_PUMP_OFF_DELAY_US * `BCD_CLK_MHZ
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // control pins from the host
  input wire logic i_sub_group_ctrl_in,
  input wire logic i_main_group_ctrl_in,
  // supply comparators
  input wire logic i_vcc_below_3v33,
  input wire logic i_vcc_above_3v36,
  input wire logic i_vcc_below_4v77,
  input wire logic i_vcc_above_4v81,
  // sink enables
  output bcd_sinks_s o_sinks,
  // charge pump
  output logic o_pump_en,
  output bcd_gain_e o_gain
);

  // ----------------------------------------------------------------------
  // input synchronisation
  // ----------------------------------------------------------------------
  bcd_pins_s raw;
  bcd_pins_s syn;

  assign raw = '{
    sub_group_ctrl_in: i_sub_group_ctrl_in,
    main_group_ctrl_in: i_main_group_ctrl_in,
    vcc_below_3v33: i_vcc_below_3v33,
    vcc_above_3v36: i_vcc_above_3v36,
    vcc_below_4v77: i_vcc_below_4v77,
    vcc_above_4v81: i_vcc_above_4v81
  };

  bcd_sync2 #(
    .W(`BCD_SYNC_W)
  ) u_sync (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_async(raw),
    .o_sync(syn)
  );

  // ----------------------------------------------------------------------
  // group decode
  // ----------------------------------------------------------------------
  wire logic s_sub;
  wire logic s_main;
  wire logic s_any;
  bcd_sinks_s next_sinks;

  assign s_sub = syn.sub_group_ctrl_in;
  assign s_main = syn.main_group_ctrl_in;
  assign s_any = s_sub | s_main;

  // full on or full off only, so average current tracks duty
  assign next_sinks = '{
    main_sink_a: s_main, // see R01, R02, R03, R05
    main_sink_b: s_main, // see R02
    main_sink_c: s_main, // see R02
    sub_sink: s_sub // see R01, R03, R05
  };

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_sinks <= '0;
    end else begin
      o_sinks <= next_sinks; // see R06
    end
  end

  // ----------------------------------------------------------------------
  // pump-off timer
  // ----------------------------------------------------------------------
  localparam logic [`BCD_TMR_W-1:0] TMR_LAST =
    `BCD_TMR_W'(PUMP_OFF_CYCLES - 1);

  logic [`BCD_TMR_W-1:0] cnt;
  wire logic [`BCD_TMR_W-1:0] next_cnt;
  wire logic timeout_hit;
  wire logic next_pump_en;

  assign timeout_hit = ~s_any & (cnt == TMR_LAST); // see R06
  // cleared at the timeout too, so a stopped pump leaves a zero count
  assign next_cnt = (s_any | ~o_pump_en | timeout_hit) ? '0 :
                    cnt + `BCD_TMR_W'(1); // see R06, R07, R12
  assign next_pump_en = s_any | (o_pump_en & ~timeout_hit); // see R06, R07

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      cnt <= '0;
      o_pump_en <= 1'b0;
    end else begin
      cnt <= next_cnt;
      o_pump_en <= next_pump_en;
    end
  end

  // ----------------------------------------------------------------------
  // gain selector
  // ----------------------------------------------------------------------
  bcd_gain_e next_gain;

  always_comb begin
    next_gain = o_gain;
    unique case (o_gain)
      BCD_G1X: begin
        if (syn.vcc_below_4v77) begin
          next_gain = BCD_G15X; // see R10
        end
      end
      BCD_G15X: begin
        if (syn.vcc_below_3v33) begin
          next_gain = BCD_G2X; // see R09
        end else if (syn.vcc_above_4v81) begin
          next_gain = BCD_G1X; // see R10
        end
      end
      BCD_G2X: begin
        if (syn.vcc_above_3v36) begin
          next_gain = BCD_G15X; // see R09
        end
      end
      default: begin
        next_gain = BCD_G15X;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_gain <= BCD_G1X;
    end else begin
      o_gain <= next_gain;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);

  property p_sync_delay;
    (!$past(i_sys_rst, 1) && !$past(i_sys_rst, 2)) |->
      (s_sub == $past(i_sub_group_ctrl_in, 2)) &&
      (s_main == $past(i_main_group_ctrl_in, 2));
  endproperty
  a_sync_delay: assert property (p_sync_delay) // see R11
    else $error("control input not delayed by two stages");

  property p_sub_follow;
    s_sub |=> o_sinks.sub_sink ##1 (o_sinks.sub_sink == $past(s_sub));
  endproperty
  a_sub_follow: assert property (p_sub_follow) // see R01
    else $error("sub sink does not follow its input");

  property p_main_group;
    (o_sinks.main_sink_a == o_sinks.main_sink_b) &&
      (o_sinks.main_sink_b == o_sinks.main_sink_c) &&
      (o_sinks.main_sink_a == $past(s_main));
  endproperty
  a_main_group: assert property (p_main_group) // see R02
    else $error("main sinks not driven together by main input");

  property p_level_step;
    $fell(s_main) |=> !o_sinks.main_sink_a && $past(o_sinks.main_sink_a);
  endproperty
  a_level_step: assert property (p_level_step) // see R03
    else $error("main sinks not switched off with input");

  property p_duty_hold;
    !s_sub [*3] |=> !o_sinks.sub_sink [*1];
  endproperty
  a_duty_hold: assert property (p_duty_hold) // see R05
    else $error("sub sink on during zero duty");

  property p_all_low_off;
    (!s_any && o_pump_en && !timeout_hit) |=>
      (o_sinks == '0) && o_pump_en;
  endproperty
  a_all_low_off: assert property (p_all_low_off) // see R06
    else $error("sinks not off or pump dropped early");

  property p_timeout;
    timeout_hit |=> !o_pump_en && (cnt == '0);
  endproperty
  a_timeout: assert property (p_timeout) // see R06
    else $error("pump not shut down at timeout");

  property p_restart;
    (s_any && o_pump_en && cnt != '0) |=> (cnt == '0) && o_pump_en;
  endproperty
  a_restart: assert property (p_restart) // see R07
    else $error("timer not restarted by a high input");

  property p_count;
    (!s_any && o_pump_en && !timeout_hit) |=> (cnt == $past(cnt) + 1'b1);
  endproperty
  a_count: assert property (p_count) // see R12
    else $error("timer does not advance while all low");

  property p_gain_2x;
    (o_gain == BCD_G15X && syn.vcc_below_3v33) |=> (o_gain == BCD_G2X)
      ##1 (o_gain == BCD_G2X || $past(syn.vcc_above_3v36));
  endproperty
  a_gain_2x: assert property (p_gain_2x) // see R09
    else $error("gain 2x step or hysteresis wrong");

  property p_gain_15x;
    (o_gain == BCD_G1X && syn.vcc_below_4v77) |=> (o_gain == BCD_G15X);
  endproperty
  a_gain_15x: assert property (p_gain_15x) // see R10
    else $error("gain 1x to 1.5x step wrong");

  property p_gain_1x;
    (o_gain == BCD_G15X && !syn.vcc_below_3v33 && syn.vcc_above_4v81)
      |=> (o_gain == BCD_G1X);
  endproperty
  a_gain_1x: assert property (p_gain_1x) // see R10
    else $error("gain 1.5x to 1x step wrong");

endmodule

//--- verification/bcd_host.sv
// host model: drives the two control pins, steady or pulse-width
// assumes a free-running i_clk; pins move 2 ns after each rising edge
module bcd_host (
  // clock
  input wire logic i_clk,
  // settings, pwm and level per pin (bit 1 main, bit 0 sub), period and duty shared by both pins
  input wire logic [1:0] i_pwm,
  input wire logic [1:0] i_lvl,
  input wire logic [17:0] i_per,
  input wire logic [17:0] i_duty,
  // pins
  output logic o_sub,
  output logic o_main
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [17:0] ph = 18'h0;
  initial begin
    o_sub = 1'b0;
    o_main = 1'b0;
  end
  always @(posedge i_clk) begin
    ph <= (ph + 18'h1 >= i_per) ? 18'h0 : ph + 18'h1;
    // steady level, or pwm with a period of i_per cycles
    o_sub <= #2 i_pwm[0] ? (ph < i_duty) : i_lvl[0];
    o_main <= #2 i_pwm[1] ? (ph < i_duty) : i_lvl[1];
  end
endmodule

//--- verification/bcd_top_bench.sv
// bench of the backlight control decoder against a cycle model
// assumes the design files and bcd_host.sv are compiled first
module bcd_top_bench
  import bcd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int P = 200;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] pwm = 2'h0;
  logic [1:0] lvl = 2'h0;
  logic [17:0] duty = 18'h0;
  logic [3:0] cmp;
  logic sub, main, pump;
  bcd_sinks_s sinks;
  bcd_gain_e gain;
  logic [15:0] dut_o, m_out = 16'h0001;
  logic [5:0] s1 = 6'h00, s2 = 6'h00;
  logic [31:0] rnd = 32'h5b30a35b;
  int bad_count = 0, comparisons = 0, mv = 5000, m_cnt = 0, t;
  assign cmp = {mv < 3330, mv > 3360, mv < 4770, mv > 4810};
  assign dut_o = {8'h00, sinks, pump, gain};
  always #20 clk = ~clk;

  bcd_host i_bcd_host (.i_clk(clk), .i_pwm(pwm), .i_lvl(lvl),
    .i_per(18'h7d), .i_duty(duty), .o_sub(sub), .o_main(main));
  bcd_top #(.PUMP_OFF_CYCLES(P)) i_bcd_top (.i_clk(clk), .i_sys_rst(rst),
    .i_sub_group_ctrl_in(sub), .i_main_group_ctrl_in(main),
    .i_vcc_below_3v33(cmp[3]), .i_vcc_above_3v36(cmp[2]),
    .i_vcc_below_4v77(cmp[1]), .i_vcc_above_4v81(cmp[0]),
    .o_sinks(sinks), .o_pump_en(pump), .o_gain(gain));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic chk(input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic test_done;
    $display("checks %0d bad %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // cycle model, compared and then stepped each falling edge
  // ----------------------------------------------------------------
  always @(negedge clk) begin
    chk(m_out, dut_o);
    if (rst) begin
      s1 = 6'h00;
      s2 = 6'h00;
      m_cnt = 0;
      m_out = 16'h0001;
    end else begin
      m_out[7:4] = {{3{s2[4]}}, s2[5]};
      if (s2[5:4] != 2'h0) begin
        m_out[3] = 1'b1;
        m_cnt = 0;
      end else if (m_out[3]) begin
        if (m_cnt == P - 1) begin
          m_out[3] = 1'b0;
          m_cnt = 0;
        end else
          m_cnt++;
      end
      case (m_out[2:0])
        3'h1: if (s2[1]) m_out[2:0] = 3'h2;
        3'h2: if (s2[3]) m_out[2:0] = 3'h4;
          else if (s2[0]) m_out[2:0] = 3'h1;
        default: if (s2[2]) m_out[2:0] = 3'h2;
      endcase
      s2 = s1;
      s1 = {sub, main, cmp};
    end
  end

  // ----------------------------------------------------------------
  // stimulus
  // ----------------------------------------------------------------
  initial begin
    #1ms;
    bad_count++;
    test_done();
  end
  initial begin
    step(12);
    rst = 1'b0;
    for (int i = 0; i < 4; i++) begin
      lvl = 2'(i);
      step(8);
    end
    for (int i = 0; i < 300; i++) begin
      rnd = xs(rnd);
      lvl = rnd[1:0];
      mv = 3000 + int'(rnd[31:20]) % 2200;
      step(1 + int'(rnd[4:2]));
    end
    for (int d = 0; d < 2; d++)
      for (int i = 0; i < 180; i++) begin
        mv = d ? 3200 + 10 * i : 5000 - 10 * i;
        step(4);
      end
    pwm = 2'h3;
    for (int k = 0; k < 3; k++) begin
      rnd = xs(rnd);
      duty = (k == 0) ? 18'h0 : (k == 1) ? 18'h3e : 18'(rnd[6:0] % 125);
      step(250);
      t = 0;
      repeat (500) begin
        @(negedge clk);
        t += int'(sinks.sub_sink);
      end
      chk(16'(t), 16'(4 * duty));
    end
    pwm = 2'h0;
    lvl = 2'h1;
    step(5);
    lvl = 2'h0;
    step(P - 20);
    lvl = 2'h2;
    step(3);
    lvl = 2'h0;
    step(P + 10);
    lvl = 2'h3;
    step(10);
    rst = 1'b1;
    step(3);
    rst = 1'b0;
    step(10);
    test_done();
  end
endmodule
